/* hdl/rsw_pkg.sv */
// rsw_pkg: constants, codes and carrier types of the radio status and whitening register bank
// assumes a 12-bit byte address window and 32-bit AXI4-Lite data
package rsw_pkg;

	// register byte offsets
	localparam logic [11:0] RSW_OFS_STRENGTH = 12'h548;
	localparam logic [11:0] RSW_OFS_PHASE    = 12'h550;
	localparam logic [11:0] RSW_OFS_SEED     = 12'h554;
	localparam logic [11:0] RSW_OFS_BCC      = 12'h560;
	localparam logic [11:0] RSW_OFS_BASE     = 12'h600;
	localparam logic [11:0] RSW_OFS_PREFIX   = 12'h620;
	localparam logic [11:0] RSW_OFS_MATCHCFG = 12'h640;
	localparam logic [11:0] RSW_OFS_STRIDE   = 12'h004;

	// sizes and field positions
	localparam int RSW_ADDR_W     = 12;
	localparam int RSW_SEGMENTS   = 8;
	localparam int RSW_IDX_W      = 3;
	localparam int RSW_IDX_LSB    = 2;
	localparam int RSW_STRENGTH_W = 7;
	localparam int RSW_PHASE_W    = 4;
	localparam int RSW_SEED_W     = 7;
	localparam int RSW_SEED_FORCE = 6;
	localparam int RSW_TAP        = 4;

	// reset values
	localparam logic [31:0] RSW_RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RSW_RST_SEED = 32'h0000_0040;

	// bus responses
	localparam logic [1:0] RSW_RESP_OKAY   = 2'h0;
	localparam logic [1:0] RSW_RESP_DECERR = 2'h3;

	// radio phase codes as reported to software
	typedef enum logic [3:0] {
		RSW_PH_DISABLED          = 4'h0,
		RSW_PH_RECEIVE_RAMPUP    = 4'h1,
		RSW_PH_RECEIVE_IDLE      = 4'h2,
		RSW_PH_RECEIVING         = 4'h3,
		RSW_PH_RECEIVE_SHUTDOWN  = 4'h4,
		RSW_PH_TRANSMIT_RAMPUP   = 4'h9,
		RSW_PH_TRANSMIT_IDLE     = 4'ha,
		RSW_PH_TRANSMITTING      = 4'hb,
		RSW_PH_TRANSMIT_SHUTDOWN = 4'hc
	} rsw_phase_t;

	// radio core status into the bank
	typedef struct packed {
		logic [RSW_PHASE_W-1:0]    phase;
		logic                      strength_valid;
		logic [RSW_STRENGTH_W-1:0] strength;
		logic [31:0]               bit_count;
	} rsw_radio_in_t;

	// received address offered for device-address matching
	typedef struct packed {
		logic        valid;
		logic [31:0] base;
		logic [31:0] prefix;
	} rsw_rx_addr_t;

	// match result
	typedef struct packed {
		logic                 hit;
		logic [RSW_IDX_W-1:0] index;
	} rsw_match_t;

	// whitening control from the radio core
	typedef struct packed {
		logic load;
		logic step;
	} rsw_whiten_ctl_t;

	// register bank state
	typedef struct packed {
		logic                                 aw_held;
		logic [RSW_ADDR_W-1:0]                aw_addr;
		logic                                 w_held;
		logic [31:0]                          w_data;
		logic [3:0]                           w_strb;
		logic                                 bvalid;
		logic [1:0]                           bresp;
		logic                                 rvalid;
		logic [31:0]                          rdata;
		logic [1:0]                           rresp;
		logic [RSW_STRENGTH_W-1:0]            strength;
		rsw_phase_t                           phase;
		logic [31:0]                          seed;
		logic [31:0]                          bcc;
		logic                                 bcc_hit;
		logic [RSW_SEGMENTS-1:0][31:0]        base;
		logic [RSW_SEGMENTS-1:0][31:0]        prefix;
		logic [RSW_SEGMENTS-1:0]              match_en;
	} rsw_bank_t;

endpackage

/* hdl/rsw_whiten.sv */
// rsw_whiten: 7-bit data-whitening scrambler loaded from the software seed
// assumes load and step come from the radio core on the same clock
`timescale 1ns/1ps
module rsw_whiten
(
	// clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// control and seed
	input  wire rsw_pkg::rsw_whiten_ctl_t      ctl,
	input  wire logic [rsw_pkg::RSW_SEED_W-1:0] seed,
	// scrambler output
	output logic                               whiten_bit,
	output logic [rsw_pkg::RSW_SEED_W-1:0]     lfsr_state
);
	import rsw_pkg::*;

	typedef struct packed {
		logic [RSW_SEED_W-1:0] lfsr;
	} rsw_whiten_state_t;

	rsw_whiten_state_t s_q;
	rsw_whiten_state_t s_d;

	// seed bit i lands in position 6-i, bit 6 of the seed always one
	function automatic logic [RSW_SEED_W-1:0] reverse_seed(input logic [RSW_SEED_W-1:0] v);
		logic [RSW_SEED_W-1:0] r;
		r = '0;
		for (int i = 0; i < RSW_SEED_W; i++)
			r[RSW_SEED_W-1-i] = v[i];
		return r;
	endfunction

	// load wins over step so a fresh packet never starts from a stale sequence
	always_comb
	begin
		s_d = s_q;
		if (ctl.load)
			s_d.lfsr = reverse_seed(seed);
		else if (ctl.step)
		begin
			s_d.lfsr = {s_q.lfsr[RSW_SEED_W-2:0], s_q.lfsr[RSW_SEED_W-1]};
			s_d.lfsr[RSW_TAP] = s_q.lfsr[RSW_TAP-1] ^ s_q.lfsr[RSW_SEED_W-1];
		end
	end

	// reset state matches the reset seed, reversed
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '{lfsr: RSW_RST_SEED[RSW_SEED_W-1:0] >> RSW_SEED_FORCE};
		else
			s_q <= s_d;
	end

	assign whiten_bit = s_q.lfsr[RSW_SEED_W-1];
	assign lfsr_state = s_q.lfsr;

endmodule

/* hdl/rsw_addr_match.sv */
// rsw_addr_match: compares a received address against eight enabled base/prefix pairs
// assumes the received address is stable while valid is high; lowest index wins
`timescale 1ns/1ps
module rsw_addr_match
#(
	parameter int SEGMENTS = 8
)
(
	// clock and reset
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// configuration from the bank
	input  wire logic [SEGMENTS-1:0][31:0]    base,
	input  wire logic [SEGMENTS-1:0][31:0]    prefix,
	input  wire logic [SEGMENTS-1:0]          match_en,
	// received address and result
	input  wire rsw_pkg::rsw_rx_addr_t        rx_addr,
	output rsw_pkg::rsw_match_t               result
);
	import rsw_pkg::*;

	typedef struct packed {
		rsw_match_t res;
	} rsw_match_state_t;

	rsw_match_state_t s_q;
	rsw_match_state_t s_d;

	// scan downward so the lowest matching index is the one kept
	always_comb
	begin
		s_d = s_q;
		s_d.res.hit = 1'b0;
		s_d.res.index = '0;
		if (rx_addr.valid)
			for (int i = SEGMENTS-1; i >= 0; i--)
				if (match_en[i] && base[i] == rx_addr.base && prefix[i] == rx_addr.prefix)
				begin
					s_d.res.hit = 1'b1;
					s_d.res.index = RSW_IDX_W'(i);
				end
	end

	// result registered, one cycle after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign result = s_q.res;

endmodule

/* hdl/rsw_regs.sv */
// rsw_regs: radio status and whitening register bank behind an AXI4-Lite slave
// assumes the radio core shares aclk; its status needs no synchroniser
// assumes the protection bits carry no meaning here; they are accepted and ignored
// Contract
// - phase field reports receive phases as 0,1,2,3,4.
// - phase field reports transmit phases as 9,10,11,12.
// - seed bit 6 always one; reset value 0x40.
// - seed bit i loads scrambler position 6-i.
// - 32-bit read-write bit-count compare value, reset zero, compared with count.
// - eight 32-bit read-write base segments at consecutive words, reset zero.
// - eight read-write prefix segments at consecutive words, reset zero, paired by index.
// - a pair joins matching only while its enable bit is one.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module rsw_regs
#(
	parameter int SEGMENTS = rsw_pkg::RSW_SEGMENTS
)
(
	// clock and reset
	input  wire logic                               aclk,
	input  wire logic                               aresetn,
	// axi4-lite write address
	input  wire logic                               s_axi_awvalid,
	output logic                                    s_axi_awready,
	input  wire logic [rsw_pkg::RSW_ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic [2:0]                         s_axi_awprot,
	// axi4-lite write data
	input  wire logic                               s_axi_wvalid,
	output logic                                    s_axi_wready,
	input  wire logic [31:0]                        s_axi_wdata,
	input  wire logic [3:0]                         s_axi_wstrb,
	// axi4-lite write response
	output logic                                    s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	output logic [1:0]                              s_axi_bresp,
	// axi4-lite read address
	input  wire logic                               s_axi_arvalid,
	output logic                                    s_axi_arready,
	input  wire logic [rsw_pkg::RSW_ADDR_W-1:0]     s_axi_araddr,
	input  wire logic [2:0]                         s_axi_arprot,
	// axi4-lite read data
	output logic                                    s_axi_rvalid,
	input  wire logic                               s_axi_rready,
	output logic [31:0]                             s_axi_rdata,
	output logic [1:0]                              s_axi_rresp,
	// radio core status
	input  wire rsw_pkg::rsw_radio_in_t             radio_in,
	output logic                                    bit_count_match,
	// whitening
	input  wire rsw_pkg::rsw_whiten_ctl_t           whiten_ctl,
	output logic                                    whiten_bit,
	// device-address matching
	input  wire rsw_pkg::rsw_rx_addr_t              rx_addr,
	output rsw_pkg::rsw_match_t                     addr_match
);
	import rsw_pkg::*;

	rsw_bank_t s_q;
	rsw_bank_t s_d;

	// one flag per mapped word group; at most one is set for any address
	typedef struct packed {
		logic strength;
		logic phase;
		logic seed;
		logic bcc;
		logic matchcfg;
		logic base;
		logic prefix;
	} rsw_sel_t;

	// transfer strobes, decoded selects and array indices of both paths
	logic                  wr_fire;
	logic                  rd_fire;
	rsw_sel_t              wr_sel;
	rsw_sel_t              rd_sel;
	logic [RSW_IDX_W-1:0]  wr_base_idx;
	logic [RSW_IDX_W-1:0]  wr_prefix_idx;
	logic [RSW_IDX_W-1:0]  rd_base_idx;
	logic [RSW_IDX_W-1:0]  rd_prefix_idx;
	logic [31:0]           cfg_merged;

	// merge write data into an old value under the byte strobes
	// byte lanes without a strobe keep their old contents
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = data[8*b +: 8];
		return r;
	endfunction

	// true when addr is a word-aligned address inside the eight-word array starting at base
	function automatic logic in_array(input logic [RSW_ADDR_W-1:0] addr,
		input logic [RSW_ADDR_W-1:0] base);
		logic [RSW_ADDR_W-1:0] lim;
		lim = base + RSW_ADDR_W'(SEGMENTS) * RSW_OFS_STRIDE;
		return addr >= base && addr < lim && addr[RSW_IDX_LSB-1:0] == '0;
	endfunction

	// word index within an array
	function automatic logic [RSW_IDX_W-1:0] arr_idx(input logic [RSW_ADDR_W-1:0] addr,
		input logic [RSW_ADDR_W-1:0] base);
		logic [RSW_ADDR_W-1:0] off;
		off = addr - base;
		return off[RSW_IDX_LSB +: RSW_IDX_W];
	endfunction

	// address decode shared by both paths, so the two maps cannot drift apart
	function automatic rsw_sel_t decode(input logic [RSW_ADDR_W-1:0] addr);
		rsw_sel_t sel;
		sel          = '0;
		sel.strength = addr == RSW_OFS_STRENGTH;
		sel.phase    = addr == RSW_OFS_PHASE;
		sel.seed     = addr == RSW_OFS_SEED;
		sel.bcc      = addr == RSW_OFS_BCC;
		sel.matchcfg = addr == RSW_OFS_MATCHCFG;
		sel.base     = in_array(addr, RSW_OFS_BASE);
		sel.prefix   = in_array(addr, RSW_OFS_PREFIX);
		return sel;
	endfunction

	// only documented phase codes get through; anything else reads as disabled
	// a stray core code can never show software an undefined value
	function automatic rsw_phase_t legal_phase(input logic [RSW_PHASE_W-1:0] code);
		rsw_phase_t p;
		case (code)
			RSW_PH_DISABLED, RSW_PH_RECEIVE_RAMPUP, RSW_PH_RECEIVE_IDLE,
			RSW_PH_RECEIVING, RSW_PH_RECEIVE_SHUTDOWN:
				p = rsw_phase_t'(code);
			RSW_PH_TRANSMIT_RAMPUP, RSW_PH_TRANSMIT_IDLE,
			RSW_PH_TRANSMITTING, RSW_PH_TRANSMIT_SHUTDOWN:
				p = rsw_phase_t'(code);
			default:
				p = RSW_PH_DISABLED;
		endcase
		return p;
	endfunction

	// seed with the hardwired bit set, upper bits held at zero
	// the bit is forced on every write, so software cannot clear it
	function automatic logic [31:0] fix_seed(input logic [31:0] v);
		logic [31:0] r;
		r = '0;
		r[RSW_SEED_W-1:0] = v[RSW_SEED_W-1:0];
		r[RSW_SEED_FORCE] = 1'b1;
		return r;
	endfunction

	// handshakes: one write and one read in flight, each address and data taken once
	// readies are combinational, so a new request is taken the cycle after a response
	assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
	assign s_axi_wready  = !s_q.w_held && !s_q.bvalid;
	assign s_axi_arready = !s_q.rvalid;
	assign wr_fire       = s_q.aw_held && s_q.w_held && !s_q.bvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;

	// both paths decode through one function
	assign wr_sel        = decode(s_q.aw_addr);
	assign rd_sel        = decode(s_axi_araddr);

	// array indices; only meaningful while the matching array flag is set
	assign wr_base_idx   = arr_idx(s_q.aw_addr, RSW_OFS_BASE);
	assign wr_prefix_idx = arr_idx(s_q.aw_addr, RSW_OFS_PREFIX);
	assign rd_base_idx   = arr_idx(s_axi_araddr, RSW_OFS_BASE);
	assign rd_prefix_idx = arr_idx(s_axi_araddr, RSW_OFS_PREFIX);

	// enables merged as a whole word, then cut to one bit per pair
	assign cfg_merged    = merge({{(32-SEGMENTS){1'b0}}, s_q.match_en}, s_q.w_data, s_q.w_strb);

	// next-state logic for the bus slave and every register
	always_comb
	begin
		s_d = s_q;

		// capture write address and data in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_held = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_held = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end

		// register writes; read-only and unmapped words answer decerr
		// a write commits only once both halves are held and the old response is gone
		if (wr_fire)
		begin
			s_d.aw_held = 1'b0;
			s_d.w_held  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = RSW_RESP_OKAY;
			if (wr_sel.seed)
				s_d.seed = fix_seed(merge(s_q.seed, s_q.w_data, s_q.w_strb));
			else if (wr_sel.bcc)
				s_d.bcc = merge(s_q.bcc, s_q.w_data, s_q.w_strb);
			else if (wr_sel.matchcfg)
				s_d.match_en = cfg_merged[SEGMENTS-1:0];
			else if (wr_sel.base)
				s_d.base[wr_base_idx] =
					merge(s_q.base[wr_base_idx], s_q.w_data, s_q.w_strb);
			else if (wr_sel.prefix)
				s_d.prefix[wr_prefix_idx] =
					merge(s_q.prefix[wr_prefix_idx], s_q.w_data, s_q.w_strb);
			else
				s_d.bresp = RSW_RESP_DECERR;
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;

		// read data decode, answered the cycle after the address is taken
		// unmapped reads return zero data with a decode error
		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (rd_fire)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RSW_RESP_OKAY;
			s_d.rdata  = '0;
			if (rd_sel.strength)
				s_d.rdata[RSW_STRENGTH_W-1:0] = s_q.strength;
			else if (rd_sel.phase)
				s_d.rdata[RSW_PHASE_W-1:0] = s_q.phase;
			else if (rd_sel.seed)
				s_d.rdata = s_q.seed;
			else if (rd_sel.bcc)
				s_d.rdata = s_q.bcc;
			else if (rd_sel.matchcfg)
				s_d.rdata[SEGMENTS-1:0] = s_q.match_en;
			else if (rd_sel.base)
				s_d.rdata = s_q.base[rd_base_idx];
			else if (rd_sel.prefix)
				s_d.rdata = s_q.prefix[rd_prefix_idx];
			else
				s_d.rresp = RSW_RESP_DECERR;
		end

		// radio status sampling; strength is only updated on a new sample
		// phase is taken every cycle, so a stale code lasts one cycle at most
		// the compare is a level, not a latched flag: it drops as the count moves on
		if (radio_in.strength_valid)
			s_d.strength = radio_in.strength;
		s_d.phase   = legal_phase(radio_in.phase);
		s_d.bcc_hit = radio_in.bit_count == s_q.bcc;
	end

	// single register stage for the whole bank
	// the seed leaves reset with its forced bit already set
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q          <= '0;
			s_q.phase    <= RSW_PH_DISABLED;
			s_q.seed     <= RSW_RST_SEED;
			s_q.bcc      <= RSW_RST_ZERO;
			s_q.strength <= '0;
		end
		else
			s_q <= s_d;
	end

	// outputs straight from flip-flops
	// only the readies above are combinational
	assign s_axi_bvalid    = s_q.bvalid;
	assign s_axi_bresp     = s_q.bresp;
	assign s_axi_rvalid    = s_q.rvalid;
	assign s_axi_rdata     = s_q.rdata;
	assign s_axi_rresp     = s_q.rresp;
	assign bit_count_match = s_q.bcc_hit;

	// scrambler uses the seed as stored, so the forced bit also acts
	// its full state stays inside; only the output bit leaves the bank
	rsw_whiten u_whiten
	(
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ctl        (whiten_ctl),
		.seed       (s_q.seed[RSW_SEED_W-1:0]),
		.whiten_bit (whiten_bit),
		.lfsr_state ()
	);

	// enabled base/prefix pairs feed the matcher
	// its result lags rx_addr by one cycle; the lowest enabled index wins
	rsw_addr_match #(.SEGMENTS(SEGMENTS)) u_match
	(
		.aclk     (aclk),
		.aresetn  (aresetn),
		.base     (s_q.base),
		.prefix   (s_q.prefix),
		.match_en (s_q.match_en),
		.rx_addr  (rx_addr),
		.result   (addr_match)
	);

endmodule

/* verification/rsw_regs_sva.sv */
// rsw_regs_sva: bus timing and register read-back checks on the bank's ports
// assumes the single aclk domain; bound to every rsw_regs instance
`timescale 1ns/1ps
module rsw_regs_sva
#(
	parameter int SEGMENTS = 8
)
(
	// clock and reset
	input wire logic                           aclk,
	input wire logic                           aresetn,
	// bus handshakes
	input wire logic                           s_axi_awvalid,
	input wire logic                           s_axi_awready,
	input wire logic                           s_axi_wvalid,
	input wire logic                           s_axi_wready,
	input wire logic                           s_axi_bvalid,
	input wire logic                           s_axi_bready,
	input wire logic [1:0]                     s_axi_bresp,
	input wire logic                           s_axi_arvalid,
	input wire logic                           s_axi_arready,
	input wire logic [rsw_pkg::RSW_ADDR_W-1:0] s_axi_araddr,
	input wire logic                           s_axi_rvalid,
	input wire logic                           s_axi_rready,
	input wire logic [31:0]                    s_axi_rdata,
	input wire logic [1:0]                     s_axi_rresp,
	// radio side
	input wire logic                           bit_count_match,
	input wire rsw_pkg::rsw_rx_addr_t          rx_addr,
	input wire rsw_pkg::rsw_match_t            addr_match
);
	import rsw_pkg::*;
	logic [RSW_ADDR_W-1:0] rd_addr_q;
	// remember the address of the read in flight, so its data can be judged
	always_ff @(posedge aclk)
	begin
		if (s_axi_arvalid && s_axi_arready)
			rd_addr_q <= s_axi_araddr;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_seed_bit: assert property (s_axi_rvalid && rd_addr_q == RSW_OFS_SEED |-> s_axi_rdata[31:6] == 26'h1)
		else $error("seed read without forced bit");
	a_phase_code: assert property (s_axi_rvalid && rd_addr_q == RSW_OFS_PHASE |-> s_axi_rdata inside {[0:4], [9:12]})
		else $error("phase read outside code set");
	a_strength_width: assert property (s_axi_rvalid && rd_addr_q == RSW_OFS_STRENGTH |-> s_axi_rdata[31:7] == 25'h0)
		else $error("strength read wider than seven bits");
	a_match_cause: assert property (addr_match.hit |-> $past(rx_addr.valid))
		else $error("match without offered address");
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !addr_match.hit)
		else $error("outputs busy after reset");
	c_decerr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RSW_RESP_DECERR);
	c_seed: cover property (s_axi_rvalid && s_axi_rready && rd_addr_q == RSW_OFS_SEED);
	c_hit: cover property (addr_match.hit);
	c_count: cover property (bit_count_match);
endmodule

bind rsw_regs rsw_regs_sva #(.SEGMENTS(SEGMENTS)) u_sva (.*);

/* verification/radio_status_whitening_regs_bench.sv */
// radio_status_whitening_regs_bench: drives the bank over its bus and radio ports
// assumes rsw_regs with default sizes; one 100 MHz clock
`timescale 1ns/1ps
module radio_status_whitening_regs_bench;
	import rsw_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic bit_count_match, whiten_bit;
	logic [RSW_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [31:0] base_v[8], pfx_v[8];
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [6:0] lf;
	rsw_radio_in_t radio_in;
	rsw_whiten_ctl_t whiten_ctl;
	rsw_rx_addr_t rx_addr;
	rsw_match_t addr_match;
	int n_errors, check_count, i, k;
	logic [33:0] rd_q[$];
	logic [1:0] b_q[$];

	rsw_regs uut (.*);

	// free-running clock
	initial
	begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	task automatic fail(input string m);
		n_errors++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	function automatic logic [33:0] ok(input logic [31:0] d);
		return {RSW_RESP_OKAY, d};
	endfunction
	task automatic cmp_read(input logic [33:0] got, input logic [33:0] exp);
		check_count++;
		if (got !== exp) fail($sformatf("read %h want %h", got, exp));
	endtask
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		check_count++;
		if (got !== exp) fail($sformatf("bresp %h want %h", got, exp));
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) fail($sformatf("bit %b want %b", got, exp));
	endtask
	task automatic cmp_match(input rsw_match_t got, input rsw_match_t exp);
		check_count++;
		if (got !== exp) fail($sformatf("match %h want %h", got, exp));
	endtask
	// each bus answer is judged against the oldest note left by the driver
	always @(posedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready)
			cmp_read({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			cmp_resp(s_axi_bresp, b_q.pop_front());
	end
	// bready and rready stay high, so valids are dropped only once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		b_q.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			n++;
		end while (!s_axi_bvalid && n < 50);
		if (!s_axi_bvalid) fail("write timeout");
		if (!s_axi_bvalid) final_report();
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		int n;
		rd_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			n++;
		end while (!s_axi_rvalid && n < 50);
		if (!s_axi_rvalid) fail("read timeout");
		if (!s_axi_rvalid) final_report();
	endtask
	// watchdog against a hung design
	initial
	begin
		repeat (20000) @(posedge aclk);
		fail("run timeout");
		final_report();
	end
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, aresetn} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		{radio_in, whiten_ctl, rx_addr} = '0;
		s_axi_wstrb = 4'hf;
		s_axi_bready = 1;
		s_axi_rready = 1;
		i = $urandom(32'h9294);
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(RSW_OFS_STRENGTH, ok(32'h0));
		rd(RSW_OFS_SEED, ok(RSW_RST_SEED));
		rd(RSW_OFS_BCC, ok(32'h0));
		for (k = 0; k < 8; k++)
		begin
			rd(RSW_OFS_BASE + 12'(k * 4), ok(32'h0));
			rd(RSW_OFS_PREFIX + 12'(k * 4), ok(32'h0));
		end
		$display("reset values done");
		// all sixteen codes; unlisted ones read as zero
		for (k = 0; k < 16; k++)
		begin
			radio_in.phase <= 4'(k);
			repeat (2) @(posedge aclk);
			rd(RSW_OFS_PHASE, ok(k inside {[0:4], [9:12]} ? 32'(k) : 32'h0));
		end
		v = $urandom;
		radio_in.strength <= v[6:0];
		radio_in.strength_valid <= 1;
		@(posedge aclk);
		radio_in.strength_valid <= 0;
		radio_in.strength <= ~v[6:0];
		@(posedge aclk);
		rd(RSW_OFS_STRENGTH, ok({25'h0, v[6:0]}));
		wr(RSW_OFS_STRENGTH, 32'h7f, RSW_RESP_DECERR);
		rd(RSW_OFS_STRENGTH, ok({25'h0, v[6:0]}));
		$display("status codes done");
		wr(RSW_OFS_SEED, 32'h0, RSW_RESP_OKAY);
		rd(RSW_OFS_SEED, ok(32'h40));
		v = $urandom;
		wr(RSW_OFS_SEED, v, RSW_RESP_OKAY);
		rd(RSW_OFS_SEED, ok({26'h1, v[5:0]}));
		whiten_ctl.load <= 1;
		@(posedge aclk);
		whiten_ctl.load <= 0;
		lf = {v[0], v[1], v[2], v[3], v[4], v[5], 1'b1};
		// settling room, then the output bit, then one step at a time
		for (k = 0; k < 9; k++)
		begin
			repeat (3) @(posedge aclk);
			cmp_bit(whiten_bit, lf[6]);
			whiten_ctl.step <= 1;
			lf = {lf[5:4], lf[3] ^ lf[6], lf[2:0], lf[6]};
			@(posedge aclk);
			whiten_ctl.step <= 0;
		end
		$display("whitening done");
		v = $urandom;
		wr(RSW_OFS_BCC, v, RSW_RESP_OKAY);
		rd(RSW_OFS_BCC, ok(v));
		radio_in.bit_count <= v;
		repeat (2) @(posedge aclk);
		cmp_bit(bit_count_match, 1'b1);
		radio_in.bit_count <= v + 32'h1;
		repeat (2) @(posedge aclk);
		cmp_bit(bit_count_match, 1'b0);
		for (k = 0; k < 8; k++)
		begin
			base_v[k] = $urandom;
			pfx_v[k] = $urandom;
			wr(RSW_OFS_BASE + 12'(k * 4), base_v[k], RSW_RESP_OKAY);
			wr(RSW_OFS_PREFIX + 12'(k * 4), pfx_v[k], RSW_RESP_OKAY);
		end
		wr(RSW_OFS_BASE + 12'h2, 32'h1, RSW_RESP_DECERR);
		rd(RSW_OFS_PREFIX + 12'h1, {RSW_RESP_DECERR, 32'h0});
		rd(12'h700, {RSW_RESP_DECERR, 32'h0});
		for (k = 0; k < 8; k++)
		begin
			rd(RSW_OFS_BASE + 12'(k * 4), ok(base_v[k]));
			rd(RSW_OFS_PREFIX + 12'(k * 4), ok(pfx_v[k]));
		end
		$display("segments done");
		// every pair matches only with its own enable
		for (k = 0; k < 8; k++)
		begin
			wr(RSW_OFS_MATCHCFG, 32'hff & ~(32'h1 << k), RSW_RESP_OKAY);
			rx_addr <= {1'b1, base_v[k], pfx_v[k]};
			repeat (2) @(posedge aclk);
			cmp_bit(addr_match.hit, 1'b0);
			wr(RSW_OFS_MATCHCFG, 32'h1 << k, RSW_RESP_OKAY);
			repeat (2) @(posedge aclk);
			cmp_match(addr_match, {1'b1, 3'(k)});
			rx_addr.valid <= 0;
		end
		rd(RSW_OFS_MATCHCFG, ok(32'h80));
		$display("matching done");
		repeat (3) @(posedge aclk);
		final_report();
	end
endmodule
